/* File: core/eag_pkg.sv */
// Package of constants and types for the effective address generator
`default_nettype none
package eag_pkg;
  // ***********************************
  // Mode encodings
  // ***********************************
  localparam logic [2:0] MODE_DREG  = 3'h0;
  localparam logic [2:0] MODE_AREG  = 3'h1;
  localparam logic [2:0] MODE_IND   = 3'h2;
  localparam logic [2:0] MODE_POST  = 3'h3;
  localparam logic [2:0] MODE_PRE   = 3'h4;
  localparam logic [2:0] MODE_DISP  = 3'h5;
  localparam logic [2:0] MODE_INDEX = 3'h6;
  localparam logic [2:0] MODE_EXTRA = 3'h7;
  localparam logic [2:0] SP_NUM     = 3'h7;
  // ***********************************
  // Steps and extension word fields
  // ***********************************
  localparam logic [31:0] STEP_BYTE = 32'h1;
  localparam logic [31:0] STEP_WORD = 32'h2;
  localparam logic [31:0] STEP_LONG = 32'h4;
  localparam int EXT_DA    = 15;
  localparam int EXT_REG   = 12;
  localparam int EXT_WL    = 11;
  localparam int EXT_SCALE = 9;
  localparam int EXT_FULL  = 8;
  // ***********************************
  // Register map and reset values
  // ***********************************
  localparam logic [3:0]  OFS_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_STATUS = 4'h4;
  localparam logic [3:0]  OFS_LAST   = 4'h8;
  localparam logic [31:0] CTRL_RST   = 32'h1;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_DEC   = 2'h3;
  // ***********************************
  // Types
  // ***********************************
  typedef enum logic [1:0] {SZ_BYTE = 2'b00, SZ_WORD = 2'b01, SZ_LONG = 2'b10} eag_size_e;
  typedef enum logic [1:0] {FORM_REG = 2'b00, FORM_EA = 2'b01, FORM_IMPL = 2'b10} eag_form_e;
  typedef enum logic [1:0] {LOC_DREG = 2'b00, LOC_AREG = 2'b01, LOC_MEM = 2'b10} eag_loc_e;
  typedef struct packed {
    eag_form_e   form;
    logic [2:0]  mode;
    logic [2:0]  regf;
    logic        is_addr;
    logic [2:0]  impl_reg;
    eag_size_e   size;
    logic        cp_en;
    logic [7:0]  cp_size;
    logic [15:0] ext;
  } eag_req_s;
  typedef struct packed {
    eag_loc_e    kind;
    logic [2:0]  rnum;
    logic [31:0] addr;
    logic [1:0]  ext_cnt;
    logic        unsup;
  } eag_loc_s;
endpackage
`default_nettype wire

/* File: core/eag_top.sv */
// Effective address generator with AXI4-Lite control and status
`default_nettype none
module eag_top
  import eag_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Decode request
  input  wire logic              req_valid,
  input  wire eag_req_s          req,
  // Register file view
  input  wire logic [7:0][31:0]  dreg_val,
  input  wire logic [7:0][31:0]  areg_val,
  // Operand location result
  output var  logic              loc_valid_r,
  output var  eag_loc_s          loc_r,
  // Address register write-back
  output var  logic              wb_valid_r,
  output var  logic [2:0]        wb_reg_r,
  output var  logic [31:0]       wb_data_r,
  // AXI4-Lite slave
  input  wire logic [3:0]        s_awaddr,
  input  wire logic              s_awvalid,
  output var  logic              s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output var  logic              s_wready,
  output var  logic [1:0]        s_bresp,
  output var  logic              s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [3:0]        s_araddr,
  input  wire logic              s_arvalid,
  output var  logic              s_arready,
  output var  logic [31:0]       s_rdata,
  output var  logic [1:0]        s_rresp,
  output var  logic              s_rvalid,
  input  wire logic              s_rready
);
  // ***********************************
  // Address computation
  // ***********************************
  logic        fire;
  logic [2:0]  m;
  logic [2:0]  rn;
  logic [31:0] base;
  logic [31:0] step;
  logic [31:0] idx_raw;
  logic [31:0] idx;
  logic [31:0] dsp16;
  logic [31:0] dsp8;
  logic        loc_valid_nxt;
  eag_loc_s    loc_nxt;
  logic        wb_valid_nxt;
  logic [2:0]  wb_reg_nxt;
  logic [31:0] wb_data_nxt;
  logic        ctrl_en_r;

  always_comb
  begin
    fire = req_valid && ctrl_en_r;
    m    = req.mode;
    rn   = req.regf;
    if (req.form == FORM_REG)
    begin
      m = req.is_addr ? MODE_AREG : MODE_DREG;
    end
    else if (req.form == FORM_IMPL)
    begin
      rn = req.impl_reg;
    end
    base = areg_val[rn];
    case (req.size)
      SZ_BYTE: step = (rn == SP_NUM) ? STEP_WORD : STEP_BYTE;
      SZ_WORD: step = STEP_WORD;
      default: step = STEP_LONG;
    endcase
    if (req.cp_en)
    begin
      step = {24'h000000, req.cp_size};
    end
    dsp16   = {{16{req.ext[15]}}, req.ext};
    dsp8    = {{24{req.ext[7]}}, req.ext[7:0]};
    idx_raw = req.ext[EXT_DA] ? areg_val[req.ext[EXT_REG+:3]]
                              : dreg_val[req.ext[EXT_REG+:3]];
    idx     = req.ext[EXT_WL] ? idx_raw
                              : {{16{idx_raw[15]}}, idx_raw[15:0]};
    idx     = idx << req.ext[EXT_SCALE+:2];
    loc_valid_nxt = fire;
    loc_nxt       = '{kind: LOC_MEM, rnum: rn, addr: base, ext_cnt: 2'h0, unsup: 1'b0};
    wb_valid_nxt  = 1'b0;
    wb_reg_nxt    = rn;
    wb_data_nxt   = base;
    case (m)
      MODE_DREG:
      begin
        loc_nxt.kind = LOC_DREG;
        loc_nxt.addr = 32'h0;
      end
      MODE_AREG:
      begin
        loc_nxt.kind = LOC_AREG;
        loc_nxt.addr = 32'h0;
      end
      MODE_IND: loc_nxt.addr = base;
      MODE_POST:
      begin
        wb_valid_nxt = fire;
        wb_data_nxt  = base + step;
      end
      MODE_PRE:
      begin
        wb_valid_nxt = fire;
        wb_data_nxt  = base - step;
        loc_nxt.addr = base - step;
      end
      MODE_DISP:
      begin
        loc_nxt.addr    = base + dsp16;
        loc_nxt.ext_cnt = 2'h1;
      end
      MODE_INDEX:
      begin
        loc_nxt.addr    = base + dsp8 + idx;
        loc_nxt.ext_cnt = 2'h1;
        loc_nxt.unsup   = req.ext[EXT_FULL];
      end
      default:
      begin
        loc_nxt.rnum  = 3'h0;
        loc_nxt.addr  = 32'h0;
        loc_nxt.unsup = 1'b1;
      end
    endcase
    if (!fire)
    begin
      loc_nxt     = loc_r;
      wb_reg_nxt  = wb_reg_r;
      wb_data_nxt = wb_data_r;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      loc_valid_r <= 1'b0;
      loc_r       <= '0;
      wb_valid_r  <= 1'b0;
      wb_reg_r    <= 3'h0;
      wb_data_r   <= 32'h0;
    end
    else
    begin
      loc_valid_r <= loc_valid_nxt;
      loc_r       <= loc_nxt;
      wb_valid_r  <= wb_valid_nxt;
      wb_reg_r    <= wb_reg_nxt;
      wb_data_r   <= wb_data_nxt;
    end
  end

  // ***********************************
  // AXI4-Lite registers
  // ***********************************
  logic        ctrl_en_nxt;
  logic [15:0] op_cnt_r;
  logic [15:0] op_cnt_nxt;
  logic [15:0] err_cnt_r;
  logic [15:0] err_cnt_nxt;
  logic        aw_h_r;
  logic        aw_h_nxt;
  logic        w_h_r;
  logic        w_h_nxt;
  logic [3:0]  awa_r;
  logic [3:0]  awa_nxt;
  logic [31:0] wd_r;
  logic [31:0] wd_nxt;
  logic        ws_r;
  logic        ws_nxt;
  logic        bv_nxt;
  logic [1:0]  br_nxt;
  logic        rv_nxt;
  logic [1:0]  rr_nxt;
  logic [31:0] rd_nxt;

  always_comb
  begin
    ctrl_en_nxt = ctrl_en_r;
    op_cnt_nxt  = op_cnt_r + {15'h0000, loc_valid_r};
    err_cnt_nxt = err_cnt_r + {15'h0000, loc_valid_r && loc_r.unsup};
    aw_h_nxt    = aw_h_r || (s_awvalid && s_awready);
    w_h_nxt     = w_h_r || (s_wvalid && s_wready);
    awa_nxt     = aw_h_r ? awa_r : s_awaddr;
    wd_nxt      = w_h_r ? wd_r : s_wdata;
    ws_nxt      = w_h_r ? ws_r : s_wstrb[0];
    bv_nxt      = s_bvalid && !s_bready;
    br_nxt      = s_bresp;
    if (aw_h_r && w_h_r && !s_bvalid)
    begin
      aw_h_nxt = 1'b0;
      w_h_nxt  = 1'b0;
      bv_nxt   = 1'b1;
      br_nxt   = RESP_OKAY;
      if (awa_r == OFS_CTRL)
      begin
        if (ws_r)
        begin
          ctrl_en_nxt = wd_r[0];
        end
      end
      else if (awa_r != OFS_STATUS && awa_r != OFS_LAST)
      begin
        br_nxt = RESP_DEC;
      end
    end
    rv_nxt = s_rvalid && !s_rready;
    rr_nxt = s_rresp;
    rd_nxt = s_rdata;
    if (s_arvalid && s_arready)
    begin
      rv_nxt = 1'b1;
      rr_nxt = RESP_OKAY;
      case (s_araddr)
        OFS_CTRL:   rd_nxt = {31'h00000000, ctrl_en_r};
        OFS_STATUS: rd_nxt = {err_cnt_r, op_cnt_r};
        OFS_LAST:   rd_nxt = loc_r.addr;
        default:
        begin
          rd_nxt = 32'h0;
          rr_nxt = RESP_DEC;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_en_r <= CTRL_RST[0];
      op_cnt_r  <= 16'h0000;
      err_cnt_r <= 16'h0000;
      aw_h_r    <= 1'b0;
      w_h_r     <= 1'b0;
      awa_r     <= 4'h0;
      wd_r      <= 32'h0;
      ws_r      <= 1'b0;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= 2'h0;
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rresp   <= 2'h0;
      s_rdata   <= 32'h0;
    end
    else
    begin
      ctrl_en_r <= ctrl_en_nxt;
      op_cnt_r  <= op_cnt_nxt;
      err_cnt_r <= err_cnt_nxt;
      aw_h_r    <= aw_h_nxt;
      w_h_r     <= w_h_nxt;
      awa_r     <= awa_nxt;
      wd_r      <= wd_nxt;
      ws_r      <= ws_nxt;
      s_awready <= !aw_h_nxt;
      s_wready  <= !w_h_nxt;
      s_bvalid  <= bv_nxt;
      s_bresp   <= br_nxt;
      s_arready <= !rv_nxt && !(s_arvalid && s_arready);
      s_rvalid  <= rv_nxt;
      s_rresp   <= rr_nxt;
      s_rdata   <= rd_nxt;
    end
  end

  // ***********************************
  // Checks
  // ***********************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_form_reg: assert property (
    fire && req.form == FORM_REG |=>
      loc_r.kind == ($past(req.is_addr) ? LOC_AREG : LOC_DREG))
    else $error("register form gave wrong kind");
  chk_impl_reg: assert property (
    fire && req.form == FORM_IMPL |=> loc_r.rnum == $past(req.impl_reg) || loc_r.unsup)
    else $error("implied register not used");
  chk_dreg_direct: assert property (
    fire && m == MODE_DREG |=> loc_r.kind == LOC_DREG && loc_r.ext_cnt == 2'h0)
    else $error("data direct mismatch");
  chk_areg_direct: assert property (
    fire && m == MODE_AREG |=> loc_r.kind == LOC_AREG && loc_r.ext_cnt == 2'h0 && !wb_valid_r)
    else $error("address direct mismatch");
  chk_indirect_addr: assert property (
    fire && m == MODE_IND |=> loc_r.addr == $past(base) && loc_r.ext_cnt == 2'h0)
    else $error("indirect address mismatch");
  chk_post_step: assert property (
    fire && m == MODE_POST && !req.cp_en |=> wb_valid_r && loc_r.addr == $past(base)
      && wb_data_r - loc_r.addr == ($past(req.size) == SZ_LONG ? 32'h4 :
         ($past(req.size) == SZ_BYTE && wb_reg_r != SP_NUM) ? 32'h1 : 32'h2))
    else $error("postincrement step wrong");
  chk_pre_step: assert property (
    fire && m == MODE_PRE |=> wb_valid_r && loc_r.addr == wb_data_r
      && $past(base) - wb_data_r == ($past(req.cp_en) ? {24'h000000, $past(req.cp_size)} :
         $past(req.size) == SZ_LONG ? 32'h4 :
         ($past(req.size) == SZ_BYTE && wb_reg_r != SP_NUM) ? 32'h1 : 32'h2))
    else $error("predecrement step wrong");
  chk_disp_sum: assert property (
    fire && m == MODE_DISP |=> loc_r.ext_cnt == 2'h1
      && loc_r.addr == $past(base) + {{16{$past(req.ext[15])}}, $past(req.ext)})
    else $error("displacement sum wrong");
  chk_index_sum: assert property (
    fire && m == MODE_INDEX |=> loc_r.ext_cnt == 2'h1 && !wb_valid_r
      && loc_r.addr == $past(base) + {{24{$past(req.ext[7])}}, $past(req.ext[7:0])} + $past(idx))
    else $error("indexed sum wrong");
  chk_extra_mode: assert property (
    fire && m == MODE_EXTRA |=> loc_valid_r && loc_r.unsup)
    else $error("extra mode not flagged");
  chk_reset_valid: assert property (disable iff (1'b0)
    !aresetn |=> !loc_valid_r && !wb_valid_r)
    else $error("valid not cleared by reset");

  cov_post_sp_byte: cover property (fire && m == MODE_POST && rn == SP_NUM
    && req.size == SZ_BYTE);
  cov_index_scaled: cover property (fire && m == MODE_INDEX && req.ext[EXT_SCALE+:2] == 2'h3);
  cov_axi_write: cover property (s_bvalid && s_bready);
endmodule
`default_nettype wire

/* File: dv/eag_rf_model.sv */
// Register file model that feeds the generator and takes its write-back
`default_nettype none
module eag_rf_model
  import eag_pkg::*;
(
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Write-back
  input  wire logic             wb_valid,
  input  wire logic [2:0]       wb_reg,
  input  wire logic [31:0]      wb_data,
  // Register contents
  output var  logic [7:0][31:0] dreg_val,
  output var  logic [7:0][31:0] areg_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Register file
  // ****************
  logic [7:0][31:0] areg_nxt;
  always_comb
  begin
    areg_nxt = areg_r;
    if (wb_valid)
      areg_nxt[wb_reg] = wb_data;
    for (int i = 0; i < 8; i++)
    begin
      dreg_val[i] = 32'h0001FFF0 + 32'(i);
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      for (int i = 0; i < 8; i++)
      begin
        areg_r[i] <= 32'(i) * 32'h100;
      end
    else
      areg_r <= areg_nxt;
  end
endmodule
`default_nettype wire

/* File: dv/effective_address_generator_tb.sv */
// Self-checking bench for the effective address generator
`default_nettype none
module effective_address_generator_tb;
  import eag_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Signals
  // ****************
  logic             aclk = 0, aresetn = 0, req_valid = 0;
  eag_req_s         req = '0, rq;
  logic [7:0][31:0] dreg_val, areg_val;
  logic             loc_valid_r, wb_valid_r, s_awready, s_wready, s_bvalid;
  logic             s_arready, s_rvalid;
  eag_loc_s         loc_r;
  logic [2:0]       wb_reg_r;
  logic [31:0]      wb_data_r, s_rdata, s_wdata = '0, last_ea = '0;
  logic [15:0]      x;
  logic [1:0]       s_bresp, s_rresp;
  logic [3:0]       s_awaddr = '0, s_araddr = '0, s_wstrb = '0;
  logic             s_awvalid = 0, s_wvalid = 0, s_arvalid = 0;
  logic             s_bready = 1, s_rready = 1;
  int               n_errors = 0, samples_checked = 0;
  always #50 aclk = ~aclk;
  eag_top eag_top_i (.aclk(aclk), .aresetn(aresetn), .req_valid(req_valid), .req(req),
    .dreg_val(dreg_val), .areg_val(areg_val), .loc_valid_r(loc_valid_r), .loc_r(loc_r),
    .wb_valid_r(wb_valid_r), .wb_reg_r(wb_reg_r), .wb_data_r(wb_data_r),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready));
  eag_rf_model eag_rf_model_i (.aclk(aclk), .aresetn(aresetn), .wb_valid(wb_valid_r),
    .wb_reg(wb_reg_r), .wb_data(wb_data_r), .dreg_val(dreg_val), .areg_r(areg_val));
  // ****************
  // Tasks
  // ****************
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stuck;
    n_errors++;
    complete_run();
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge aclk);
      if (s_awvalid && s_awready)
        s_awvalid <= 1'b0;
      if (s_wvalid && s_wready)
        s_wvalid <= 1'b0;
      if (s_bvalid)
        break;
    end
    if (k == 40)
      stuck();
    cmp("bresp", er, s_bresp);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge aclk);
      if (s_arvalid && s_arready)
        s_arvalid <= 1'b0;
      if (s_rvalid)
        break;
    end
    if (k == 40)
      stuck();
    cmp("rdata", ed, s_rdata);
    cmp("rresp", er, s_rresp);
  endtask
  function automatic eag_req_s mk(input eag_form_e f, input logic [2:0] m, input logic [2:0] g,
                                  input eag_size_e s, input logic [15:0] e);
    mk = '{form: f, mode: m, regf: g, size: s, ext: e, default: '0};
  endfunction
  task automatic gen(input eag_req_s r, input logic en);
    logic [31:0] a, ea, st, ix, wd;
    logic [2:0]  n;
    logic [1:0]  k, ec;
    logic        us, wb;
    n = (r.form == FORM_IMPL) ? r.impl_reg : r.regf;
    a = areg_val[n];
    st = (r.size == SZ_LONG) ? STEP_LONG : STEP_WORD;
    if (r.size == SZ_BYTE && n != SP_NUM)
      st = STEP_BYTE;
    if (r.cp_en)
      st = {24'h0, r.cp_size};
    ix = r.ext[EXT_DA] ? areg_val[r.ext[14:12]] : dreg_val[r.ext[14:12]];
    if (!r.ext[EXT_WL])
      ix = {{16{ix[15]}}, ix[15:0]};
    ix = ix << r.ext[10:9];
    {k, ec, us, wb, ea, wd} = {LOC_MEM, 2'h0, 2'h0, a, a};
    if (r.form == FORM_REG)
      {k, ea} = {1'b0, r.is_addr, 32'h0};
    else
      case (r.mode)
        MODE_DREG:  {k, ea} = {LOC_DREG, 32'h0};
        MODE_AREG:  {k, ea} = {LOC_AREG, 32'h0};
        MODE_IND:   ;
        MODE_POST:  {wb, wd} = {1'b1, a + st};
        MODE_PRE:   {wb, ea, wd} = {1'b1, a - st, a - st};
        MODE_DISP:  {ec, ea} = {2'h1, a + {{16{r.ext[15]}}, r.ext}};
        MODE_INDEX: {ec, us, ea} = {2'h1, r.ext[EXT_FULL], a + {{24{r.ext[7]}}, r.ext[7:0]} + ix};
        default:    {us, ea} = {1'b1, 32'h0};
      endcase
    @(posedge aclk);
    req <= r;
    req_valid <= 1'b1;
    @(posedge aclk);
    req_valid <= 1'b0;
    #1;
    cmp("loc_valid", en, loc_valid_r);
    cmp("wb_valid", en & wb, wb_valid_r);
    if (en)
    begin
      last_ea = ea;
      cmp("unsup", us, loc_r.unsup);
      cmp("addr", ea, loc_r.addr);
      if (!us)
        cmp("kind", k, loc_r.kind);
      if (!us)
        cmp("ext_cnt", ec, loc_r.ext_cnt);
      if (k != LOC_MEM)
        cmp("rnum", n, loc_r.rnum);
      if (wb)
        cmp("wb_reg", n, wb_reg_r);
      if (wb)
        cmp("wb_data", wd, wb_data_r);
    end
    axi_rd(OFS_LAST, last_ea, RESP_OKAY);
  endtask
  // ****************
  // Sequence
  // ****************
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(OFS_CTRL, CTRL_RST, RESP_OKAY);
    axi_rd(4'hC, 32'h0, RESP_DEC);
    axi_wr(4'hC, 32'h0, RESP_DEC);
    for (int m = 0; m < 8; m++)
      gen(mk(FORM_EA, 3'(m), 3'h3, SZ_WORD, 16'hAA04), 1'b1);
    for (int s = 0; s < 3; s++)
      for (int g = 2; g < 8; g += 5)
      begin
        gen(mk(FORM_EA, MODE_POST, 3'(g), eag_size_e'(s), 16'h0), 1'b1);
        gen(mk(FORM_EA, MODE_PRE, 3'(g), eag_size_e'(s), 16'h0), 1'b1);
      end
    gen(mk(FORM_EA, MODE_PRE, 3'h0, SZ_BYTE, 16'h0), 1'b1);
    rq = mk(FORM_EA, MODE_POST, 3'h7, SZ_BYTE, 16'h0);
    rq.cp_en = 1'b1;
    rq.cp_size = 8'hFF;
    gen(rq, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      x = {i[3], 3'h5, i[2:0], 1'b0, 8'hF0};
      gen(mk(FORM_EA, MODE_INDEX, 3'h1, SZ_LONG, x), 1'b1);
    end
    gen(mk(FORM_EA, MODE_INDEX, 3'h1, SZ_LONG, 16'h0100), 1'b1);
    rq = mk(FORM_REG, MODE_IND, 3'h6, SZ_WORD, 16'h0);
    rq.is_addr = 1'b1;
    gen(rq, 1'b1);
    rq.is_addr = 1'b0;
    gen(rq, 1'b1);
    rq = mk(FORM_IMPL, MODE_PRE, 3'h1, SZ_LONG, 16'h0);
    rq.impl_reg = 3'h7;
    gen(rq, 1'b1);
    axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
    gen(mk(FORM_EA, MODE_POST, 3'h4, SZ_LONG, 16'h0), 1'b0);
    axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
    axi_rd(OFS_CTRL, 32'h1, RESP_OKAY);
    axi_rd(OFS_STATUS, 32'h0002002A, RESP_OKAY);
    axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp("loc_valid", 32'h0, loc_valid_r);
    axi_rd(OFS_CTRL, CTRL_RST, RESP_OKAY);
    axi_rd(OFS_STATUS, 32'h0, RESP_OKAY);
    complete_run();
  end
endmodule
`default_nettype wire
